// *** logic/cfg_bank_params.svh ***
// offsets, field positions, reset values and timing counts of the configuration bank
`ifndef CFG_BANK_PARAMS_SVH
`define CFG_BANK_PARAMS_SVH
`define OFF_CARD_CTRL 12'h0000
`define OFF_USER_PIN 12'h0004
`define OFF_BOOT_MEM 12'h0008
`define OFF_DMA_TIMING 12'h000C
`define OFF_SOFT_RST 12'h003C
`define OFF_STATUS 12'h0040
`define RST_CARD_CTRL 8'h00
`define RST_USER_PIN 8'h04
`define RST_BOOT_MEM 8'hC0
`define RST_DMA_TIMING 8'h04
`define RST_SOFT_RST 8'h00
`define BIT_CARD_EN 0
`define BIT_IRQ_UNMASK 3
`define BIT_T800_EN 4
`define BIT_HOLD_LONG 5
`define BIT_PREEMPT 1
`define BIT_HUB_RX_N 2
`define BIT_EXT_CODEC 3
`define BIT_HOLD_OFF_B 4
`define BIT_WR_NO_EXT 2
`define BIT_EARLY_RDY 3
`define BIT_CHK_DIS 6
`define BIT_SW_RST 7
`define HOLD_SHORT_US 6
`define HOLD_LONG_US 12
`define WR_EXT_NS 50
`define CLK_MHZ 20
`define CLK_NS 50
`define HOLD_SHORT_CYC ((`HOLD_SHORT_US * `CLK_MHZ))
`define HOLD_LONG_CYC ((`HOLD_LONG_US * `CLK_MHZ))
`define WR_EXT_CYC (((`WR_EXT_NS + `CLK_NS - 1) / `CLK_NS))
`endif

// *** logic/cfg_bank_pkg.sv ***
// types shared by the configuration bank modules
package cfg_bank_pkg;
  typedef enum logic [1:0] {IRQ_LINE3, IRQ_LINE4, IRQ_LINE5, IRQ_LINE9} irq_sel_t;
  typedef enum logic [1:0] {DMA_CH3, DMA_CH5, DMA_CH6, DMA_CH7} dma_sel_t;
  typedef enum logic [1:0] {BOOT_RSVD, BOOT_16K, BOOT_8K, BOOT_OFF} boot_size_t;
  typedef enum logic [1:0] {RATE_5, RATE_6P7, RATE_8, RATE_10} xfer_rate_t;
endpackage : cfg_bank_pkg

// *** logic/cfg_wr_if.sv ***
// register write strobes from the bus slave to the register store
`timescale 1ns/10ps
interface cfg_wr_if;
  logic [3:0] regSel;
  logic wrEn;
  logic [7:0] wrData;
  modport slave (output regSel, output wrEn, output wrData);
  modport store (input regSel, input wrEn, input wrData);
endinterface : cfg_wr_if

// *** logic/cfg_apb_slave.sv ***
// apb slave front end: decode and write strobes
`timescale 1ns/10ps
`include "cfg_bank_params.svh"
module cfg_apb_slave (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic cardLost,
  output logic pready,
  output logic pslverr,
  output logic accessNow,
  output logic [3:0] rdSel,
  cfg_wr_if.slave wr
);
  // ************************************************************
  // address decode, zero wait states
  // ************************************************************
  function automatic logic [3:0] decodeSel(input logic [11:0] a);
    case (a)
      `OFF_CARD_CTRL: decodeSel = 4'h1;
      `OFF_USER_PIN: decodeSel = 4'h2;
      `OFF_BOOT_MEM: decodeSel = 4'h3;
      `OFF_DMA_TIMING: decodeSel = 4'h4;
      `OFF_SOFT_RST: decodeSel = 4'h5;
      `OFF_STATUS: decodeSel = 4'h6;
      default: decodeSel = 4'h0;
    endcase
  endfunction : decodeSel
  wire logic [3:0] sel = decodeSel(paddr);
  // a lost card answers every access with an error
  assign accessNow = psel && penable && !sys_rst;
  assign pready = psel && penable;
  assign pslverr = pready && (sel == 4'h0 || cardLost);
  assign rdSel = cardLost ? 4'h0 : sel;
  assign wr.regSel = sel;
  assign wr.wrEn = accessNow && pwrite && !cardLost;
  assign wr.wrData = pwdata[7:0];
endmodule : cfg_apb_slave

// *** logic/hold_timer.sv ***
// bus hold window timer after dma acknowledge
`timescale 1ns/10ps
`include "cfg_bank_params.svh"
module hold_timer #(
  parameter int SHORT_CYC = `HOLD_SHORT_CYC,
  parameter int LONG_CYC = `HOLD_LONG_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic enable,
  input wire logic longSel,
  input wire logic dackSeen,
  output logic expired
);
  logic [8:0] cnt_reg;
  logic [8:0] cnt_next;
  logic run_reg;
  wire logic [8:0] limit = longSel ? 9'(LONG_CYC) : 9'(SHORT_CYC);
  // count while acknowledge held; expiry forces the bus to be released
  assign cnt_next = (!enable || !dackSeen) ? 9'h000 : (cnt_reg == limit ? cnt_reg : cnt_reg + 9'h001);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= 9'h000;
      run_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= enable && dackSeen;
    end
  end
  assign expired = run_reg && (cnt_reg == limit);
  // ************************************************************
  // checks
  // ************************************************************
  hold_limit_a: assert property (@(posedge clk) disable iff (sys_rst)
    (cnt_reg == limit && enable && dackSeen) |-> expired) else $error("hold expiry missed");
endmodule : hold_timer

// *** logic/cfg_bank.sv ***
// configuration register bank of the host-bus interface, apb reachable
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/10ps
`include "cfg_bank_params.svh"
module cfg_bank #(
  parameter bit REVISED = 1'b1,
  parameter int HOLD_SHORT = `HOLD_SHORT_CYC,
  parameter int HOLD_LONG = `HOLD_LONG_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic netIrqPin,
  input wire logic dmaAckPin,
  input wire logic memWrReq,
  output logic [3:0] hostIrq,
  output cfg_bank_pkg::dma_sel_t dmaChannel,
  output cfg_bank_pkg::boot_size_t bootSize,
  output cfg_bank_pkg::xfer_rate_t xferRate,
  output logic [3:0] bootAddr,
  output logic [2:0] ioBaseSel,
  output logic cardEnabled,
  output logic timer800En,
  output logic holdExpired,
  output logic preemption_enable_pin,
  output logic hub_receive_enable_pin_n,
  output logic external_codec_select_pin,
  output logic earlyReady,
  output logic chanCheckOff,
  output logic memWrStrobe,
  output logic softResetActive
);
  import cfg_bank_pkg::*;
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [1:0] irqSync_reg;
  logic [1:0] dackSync_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irqSync_reg <= 2'b00;
      dackSync_reg <= 2'b00;
    end else begin
      irqSync_reg <= {irqSync_reg[0], netIrqPin};
      dackSync_reg <= {dackSync_reg[0], dmaAckPin};
    end
  end
  wire logic netIrq = irqSync_reg[1];
  wire logic dackSeen = dackSync_reg[1];
  // ************************************************************
  // bus slave
  // ************************************************************
  cfg_wr_if wr ();
  logic accessNow;
  logic [3:0] rdSel;
  logic cardLost_reg;
  cfg_apb_slave u_slave (
    .clk(clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .cardLost(cardLost_reg),
    .pready(pready),
    .pslverr(pslverr),
    .accessNow(accessNow),
    .rdSel(rdSel),
    .wr(wr.slave)
  );
  // ************************************************************
  // register store
  // ************************************************************
  logic [7:0] cardCtrl_reg;
  logic [7:0] userPin_reg;
  logic [7:0] bootMem_reg;
  logic [7:0] dmaTiming_reg;
  logic [7:0] softRst_reg;
  logic disabled_reg;
  wire logic wrCard = wr.wrEn && wr.regSel == 4'h1;
  wire logic wrUser = wr.wrEn && wr.regSel == 4'h2;
  wire logic wrBoot = wr.wrEn && wr.regSel == 4'h3;
  wire logic wrDma = wr.wrEn && wr.regSel == 4'h4;
  wire logic wrSoft = wr.wrEn && wr.regSel == 4'h5;
  wire logic swRst = REVISED && softRst_reg[`BIT_SW_RST];
  // soft reset keeps the four config registers and bits 5:3 of itself
  wire logic [7:0] softKeep = 8'h38;
  wire logic [7:0] softRst_next = wrSoft ? wr.wrData
    : (swRst ? ((softRst_reg & softKeep) | 8'h80) : softRst_reg);
  // all defaults set by synchronous reset, ready on first access
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cardCtrl_reg <= `RST_CARD_CTRL;
      userPin_reg <= `RST_USER_PIN;
      bootMem_reg <= `RST_BOOT_MEM;
      dmaTiming_reg <= `RST_DMA_TIMING;
      softRst_reg <= `RST_SOFT_RST;
    end else begin
      if (wrCard) cardCtrl_reg <= wr.wrData;
      if (wrUser) userPin_reg <= wr.wrData;
      if (wrBoot) bootMem_reg <= wr.wrData;
      if (wrDma) dmaTiming_reg <= wr.wrData;
      softRst_reg <= softRst_next;
    end
  end
  // ************************************************************
  // sticky disable and lost card, cleared only by hard reset
  // ************************************************************
  wire logic disable_next = disabled_reg || (!REVISED && wrCard && !wr.wrData[`BIT_CARD_EN]);
  wire logic lost_next = cardLost_reg || (!REVISED && wrSoft && wr.wrData[`BIT_SW_RST]);
  logic seenEnable_reg;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      disabled_reg <= 1'b0;
      cardLost_reg <= 1'b0;
      seenEnable_reg <= 1'b0;
    end else begin
      disabled_reg <= disable_next && seenEnable_reg;
      cardLost_reg <= lost_next;
      seenEnable_reg <= seenEnable_reg || (wrCard && wr.wrData[`BIT_CARD_EN]);
    end
  end
  // disable only counts once software has enabled the card
  assign cardEnabled = REVISED ? 1'b1 : (cardCtrl_reg[`BIT_CARD_EN] && !disabled_reg);
  // ************************************************************
  // interrupt routing
  // ************************************************************
  wire irq_sel_t irqSel = irq_sel_t'(cardCtrl_reg[2:1]);
  wire logic irqGated = netIrq && cardCtrl_reg[`BIT_IRQ_UNMASK] && cardEnabled;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_irq
      assign hostIrq[gi] = irqGated && (irqSel == irq_sel_t'(gi));
    end
  endgenerate
  // ************************************************************
  // field outputs
  // ************************************************************
  assign timer800En = REVISED ? cardCtrl_reg[`BIT_T800_EN] : 1'b1;
  wire logic holdEn = REVISED ? !userPin_reg[`BIT_HOLD_OFF_B] : userPin_reg[`BIT_PREEMPT];
  assign preemption_enable_pin = REVISED ? 1'b1 : userPin_reg[`BIT_PREEMPT];
  assign hub_receive_enable_pin_n = userPin_reg[`BIT_HUB_RX_N];
  assign external_codec_select_pin = userPin_reg[`BIT_EXT_CODEC];
  assign ioBaseSel = userPin_reg[7:5];
  assign bootSize = boot_size_t'(bootMem_reg[7:6]);
  assign bootAddr = bootMem_reg[5:2];
  assign dmaChannel = dma_sel_t'(dmaTiming_reg[1:0]);
  assign earlyReady = REVISED && dmaTiming_reg[`BIT_EARLY_RDY];
  assign xferRate = xfer_rate_t'(dmaTiming_reg[5:4]);
  assign chanCheckOff = dmaTiming_reg[`BIT_CHK_DIS];
  assign softResetActive = swRst;
  // ************************************************************
  // hold timer
  // ************************************************************
  hold_timer #(.SHORT_CYC(HOLD_SHORT), .LONG_CYC(HOLD_LONG)) u_hold (
    .clk(clk),
    .sys_rst(sys_rst || swRst),
    .enable(holdEn),
    .longSel(cardCtrl_reg[`BIT_HOLD_LONG]),
    .dackSeen(dackSeen),
    .expired(holdExpired)
  );
  // ************************************************************
  // write strobe stretch, one extra cycle covers 50 ns
  // ************************************************************
  localparam int EXT_CYC = `WR_EXT_CYC;
  logic [1:0] ext_reg;
  logic wrReqD_reg;
  wire logic stretchOn = !dmaTiming_reg[`BIT_WR_NO_EXT];
  wire logic fallEdge = wrReqD_reg && !memWrReq;
  always_ff @(posedge clk) begin
    if (sys_rst || swRst) begin
      ext_reg <= 2'b00;
      wrReqD_reg <= 1'b0;
    end else begin
      wrReqD_reg <= memWrReq;
      ext_reg <= (fallEdge && stretchOn) ? 2'(EXT_CYC - 1) : (ext_reg != 2'b00 ? ext_reg - 2'b01 : 2'b00);
    end
  end
  // the fall cycle itself is the first extra cycle, so the strobe never drops in between
  assign memWrStrobe = memWrReq || (fallEdge && stretchOn) || (ext_reg != 2'b00);
  // ************************************************************
  // read data, status word shows live state
  // ************************************************************
  wire logic [7:0] statusByte = {4'h0, holdExpired, cardLost_reg, swRst, cardEnabled};
  logic [7:0] rdByte;
  always_comb begin
    case (rdSel)
      4'h1: rdByte = cardCtrl_reg;
      4'h2: rdByte = userPin_reg;
      4'h3: rdByte = bootMem_reg;
      4'h4: rdByte = dmaTiming_reg;
      4'h5: rdByte = softRst_reg;
      4'h6: rdByte = statusByte;
      default: rdByte = 8'h00;
    endcase
  end
  assign prdata = {24'h00_0000, rdByte};
  // ************************************************************
  // checks
  // ************************************************************
  sticky_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!REVISED && disabled_reg) |=> !cardEnabled) else $error("card re-enabled");
  rev_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
    REVISED |-> cardEnabled) else $error("revised card disabled");
  irq_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    irqGated |-> hostIrq[cardCtrl_reg[2:1]]) else $error("irq not routed");
  irq_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cardCtrl_reg[`BIT_IRQ_UNMASK] |-> hostIrq == 4'h0) else $error("masked irq seen");
  timer_orig_a: assert property (@(posedge clk) disable iff (sys_rst)
    !REVISED |-> timer800En) else $error("timer off on original");
  hub_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrUser |=> hub_receive_enable_pin_n == $past(wr.wrData[`BIT_HUB_RX_N])) else $error("hub pin stale");
  codec_pin_a: assert property (@(posedge clk) disable iff (sys_rst)
    wrUser |=> external_codec_select_pin == $past(wr.wrData[`BIT_EXT_CODEC])) else $error("codec pin stale");
  soft_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
    (swRst && !wr.wrEn) |=> $stable(cardCtrl_reg) && $stable(dmaTiming_reg)) else $error("kept reg lost");
  lost_card_a: assert property (@(posedge clk) disable iff (sys_rst)
    cardLost_reg |-> (pslverr || !pready)) else $error("lost card answered");
  wr_stretch_a: assert property (@(posedge clk) disable iff (sys_rst || swRst)
    (fallEdge && stretchOn) |-> memWrStrobe) else $error("strobe not stretched");
  cv_irq_c: cover property (@(posedge clk) hostIrq != 4'h0);
  cv_soft_c: cover property (@(posedge clk) swRst);
  cv_hold_c: cover property (@(posedge clk) holdExpired);
endmodule : cfg_bank

// *** verif/host_side_model.sv ***
// far-side model: network controller interrupt, dma acknowledge and memory write requests
`timescale 1ns/10ps
module host_side_model (
  input wire logic clk,
  input wire logic irqOn,
  input wire logic dackOn,
  input wire logic wrGo,
  output logic netIrqPin,
  output logic dmaAckPin,
  output logic memWrReq
);
  logic [1:0] wrCnt;
  // quiet pins at time zero so the synchronisers never see unknowns
  initial begin
    netIrqPin = 1'b0;
    dmaAckPin = 1'b0;
    memWrReq = 1'b0;
    wrCnt = 2'h0;
  end
  // pins move only just after an edge; one write request lasts two cycles
  always @(posedge clk) begin
    netIrqPin <= irqOn;
    dmaAckPin <= dackOn;
    if (wrGo) begin
      wrCnt <= 2'h2;
    end else if (wrCnt != 2'h0) begin
      wrCnt <= wrCnt - 2'h1;
    end
    memWrReq <= wrGo | (wrCnt > 2'h1);
  end
endmodule : host_side_model

// *** verif/testbench.sv ***
// self-checking bench for the configuration bank over apb
`timescale 1ns/10ps
module testbench;
  import cfg_bank_pkg::*;
  // ****************
  // signals and instances
  // ****************
  logic clk, sys_rst, penable, pwrite, tgt, errVal, pready, pready2, pslverr, pslverr2;
  logic [1:0] pselV;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, prdata2, rdVal;
  logic irqOn, dackOn, wrGo, netIrqPin, dmaAckPin, memWrReq;
  logic [3:0] hostIrq, bootAddr;
  dma_sel_t dmaChannel;
  boot_size_t bootSize;
  xfer_rate_t xferRate;
  logic [2:0] ioBaseSel;
  logic cardEnabled, timer800En, holdExpired, preemptPin, hubRxPinN, extCodecPin;
  logic earlyReady, chanCheckOff, memWrStrobe, softResetActive, cardEn2, preempt2;
  logic [7:0] upv [3];
  int errTotal, nChecks, cyc;
  // short hold counts keep the timer runs brief
  cfg_bank #(.HOLD_SHORT(8), .HOLD_LONG(16)) dut_u (.clk, .sys_rst, .psel(pselV[0]),
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .netIrqPin, .dmaAckPin, .memWrReq,
    .hostIrq, .dmaChannel, .bootSize, .xferRate, .bootAddr, .ioBaseSel, .cardEnabled, .timer800En,
    .holdExpired, .preemption_enable_pin(preemptPin), .hub_receive_enable_pin_n(hubRxPinN),
    .external_codec_select_pin(extCodecPin), .earlyReady, .chanCheckOff, .memWrStrobe, .softResetActive);
  // original variant shares the bus lines but has its own select
  cfg_bank #(.REVISED(1'b0), .HOLD_SHORT(8), .HOLD_LONG(16)) orig_u (.clk, .sys_rst, .psel(pselV[1]),
    .penable, .pwrite, .paddr, .pwdata, .prdata(prdata2), .pready(pready2), .pslverr(pslverr2), .netIrqPin,
    .dmaAckPin, .memWrReq, .hostIrq(), .dmaChannel(), .bootSize(), .xferRate(), .bootAddr(), .ioBaseSel(),
    .cardEnabled(cardEn2), .timer800En(), .holdExpired(), .preemption_enable_pin(preempt2),
    .hub_receive_enable_pin_n(), .external_codec_select_pin(), .earlyReady(), .chanCheckOff(),
    .memWrStrobe(), .softResetActive());
  host_side_model far_u (.clk, .irqOn, .dackOn, .wrGo, .netIrqPin, .dmaAckPin, .memWrReq);
  // 50 ns clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude();
    if (errTotal == 0 && nChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge clk);
    pselV[tgt] <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(tgt ? pready2 : pready) && n < 40);
    if (n >= 40) errTotal++;
    rdVal = tgt ? prdata2 : prdata;
    errVal = tgt ? pslverr2 : pslverr;
    pselV <= 2'b00;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d);
    tick(1);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 8'h00);
    chk(rdVal, {24'h00_0000, e});
    chk(errVal, 1'b0);
  endtask : rd
  // hang guard: a few thousand cycles is far beyond the sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errTotal++;
      conclude();
    end
  end
  // ****************
  // scenarios
  // ****************
  initial begin
    int n;
    sys_rst = 1'b1;
    pselV = 2'b00;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    irqOn = 1'b0;
    dackOn = 1'b0;
    wrGo = 1'b0;
    tgt = 1'b0;
    errTotal = 0;
    nChecks = 0;
    cyc = 0;
    upv = '{8'h08, 8'hE4, 8'h54};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(12'h000, 8'h00);
    rd(12'h004, 8'h04);
    rd(12'h008, 8'hC0);
    rd(12'h00C, 8'h04);
    rd(12'h03C, 8'h00);
    chk(hubRxPinN, 1'b1);
    irqOn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(12'h000, {3'b000, i[0], 1'b1, i[1:0], 1'b1});
      tick(4);
      chk(hostIrq, 4'h1 << i);
      chk(timer800En, i[0]);
    end
    wr(12'h000, 8'h06);
    tick(4);
    chk(hostIrq, 4'h0);
    chk(cardEnabled, 1'b1);
    irqOn <= 1'b0;
    // last table entry also turns the hold timer off on the revised part
    foreach (upv[k]) begin
      wr(12'h004, upv[k]);
      chk(ioBaseSel, upv[k][7:5]);
      chk(hubRxPinN, upv[k][2]);
      chk(extCodecPin, upv[k][3]);
    end
    dackOn <= 1'b1;
    tick(30);
    chk(holdExpired, 1'b0);
    dackOn <= 1'b0;
    wr(12'h004, 8'h04);
    for (int j = 0; j < 2; j++) begin
      wr(12'h000, {2'b00, j[0], 5'h01});
      dackOn <= 1'b1;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (holdExpired !== 1'b1 && n < 60);
      chk(n >= 8 * (j + 1) && n <= 8 * (j + 1) + 6, 1'b1);
      dackOn <= 1'b0;
      tick(4);
    end
    // strobe stretch only while the extension bit is clear
    for (int s = 0; s < 2; s++) begin
      wr(12'h00C, s ? 8'h04 : 8'h00);
      wrGo <= 1'b1;
      @(posedge clk);
      wrGo <= 1'b0;
      tick(2);
      chk(memWrStrobe, 1'b1);
      tick(1);
      chk(memWrStrobe, !s);
      tick(1);
      chk(memWrStrobe, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(12'h00C, {2'b01, i[1:0], i[0], 1'b1, i[1:0]});
      chk(dmaChannel, i);
      chk(xferRate, i);
      chk(earlyReady, i[0]);
      chk(chanCheckOff, 1'b1);
    end
    for (int i = 1; i < 4; i++) begin
      wr(12'h008, {i[1:0], ~i[1:0], i[1:0], 2'b00});
      chk(bootSize, i);
      chk(bootAddr, {~i[1:0], i[1:0]});
    end
    wr(12'h03C, 8'hB8);
    dackOn <= 1'b1;
    tick(30);
    chk(softResetActive, 1'b1);
    chk(holdExpired, 1'b0);
    rd(12'h008, 8'hCC);
    rd(12'h03C, 8'hB8);
    dackOn <= 1'b0;
    wr(12'h03C, 8'h38);
    chk(softResetActive, 1'b0);
    rd(12'h03C, 8'h38);
    xfer(12'h020, 1'b0, 8'h00);
    chk(errVal, 1'b1);
    // original variant: sticky disable and lost card
    tgt = 1'b1;
    wr(12'h004, 8'h06);
    chk(preempt2, 1'b1);
    wr(12'h004, 8'h04);
    chk(preempt2, 1'b0);
    wr(12'h000, 8'h01);
    chk(cardEn2, 1'b1);
    wr(12'h000, 8'h00);
    chk(cardEn2, 1'b0);
    wr(12'h000, 8'h01);
    chk(cardEn2, 1'b0);
    wr(12'h03C, 8'h80);
    xfer(12'h000, 1'b0, 8'h00);
    chk(errVal, 1'b1);
    conclude();
  end
endmodule : testbench
